// ===== pssc_pkg.sv
// package: constants and carrier types for the supply supervisory control block
package pssc_pkg;
  // time figures as printed, in microseconds; clock period in nanoseconds
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned T_SB_MAIN_DEL_US = 150000; // typ standby-to-main delay
  localparam int unsigned T_PWOK_DEL_US = 150000; // typ regulation-to-power-good delay
  localparam int unsigned T_PWOK_LOW_US = 100000; // least power-good low time
  localparam int unsigned T_REQ_OFF_US = 3000; // typ request-off to main disable
  localparam int unsigned T_OFF_HOLD_US = 1000000; // typ keep-off after losing regulation
  localparam int unsigned T_BLINK1_US = 500000; // half period of 1 Hz blink
  localparam int unsigned T_BLINK2_US = 250000; // half period of 2 Hz blink
  // derived counts (cycles)
  localparam int unsigned C_SB_MAIN_DEL = T_SB_MAIN_DEL_US * 1000 / CLK_NS;
  localparam int unsigned C_PWOK_DEL = T_PWOK_DEL_US * 1000 / CLK_NS;
  localparam int unsigned C_PWOK_LOW = (T_PWOK_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned C_REQ_OFF = T_REQ_OFF_US * 1000 / CLK_NS;
  // wide product first so the 1 s figure cannot overflow, then cut back to 32 bits
  localparam int unsigned C_OFF_HOLD = 32'(64'(T_OFF_HOLD_US) * 1000 / CLK_NS);
  localparam int unsigned C_BLINK1 = T_BLINK1_US * 1000 / CLK_NS;
  localparam int unsigned C_BLINK2 = T_BLINK2_US * 1000 / CLK_NS;
  localparam int unsigned CNT_W = 28; // covers the 1 s hold
  // led colour codes
  typedef enum logic [1:0] {
    PSSC_LED_OFF = 2'h0,
    PSSC_LED_GREEN = 2'h1,
    PSSC_LED_AMBER = 2'h2
  } pssc_led_t;
  // main output sequencing states
  typedef enum logic [2:0] {
    PSSC_ST_WAIT_SB = 3'h0,
    PSSC_ST_DELAY = 3'h1,
    PSSC_ST_ON = 3'h2,
    PSSC_ST_TURN_OFF = 3'h3,
    PSSC_ST_HOLD_OFF = 3'h4,
    PSSC_ST_STANDBY = 3'h5
  } pssc_state_t;
  // status inputs from monitors
  typedef struct packed {
    logic ac_ok;
    logic sb_ok;
    logic sb_ext;
    logic main_ok;
    logic ot_shut;
    logic ov_shut;
    logic oc_shut;
    logic fan_major;
    logic ot_warn;
    logic fan_minor;
    logic boot_load;
  } pssc_stat_t;
endpackage : pssc_pkg

// ===== pssc_ctrl.sv
// module: supervisory control of a redundant front-end power supply
`timescale 1ns/1ps
`default_nettype none
module pssc_ctrl
  import pssc_pkg::*;
#(
  parameter int unsigned P_SB_MAIN_DEL = C_SB_MAIN_DEL, // standby-to-main delay cycles
  parameter int unsigned P_PWOK_DEL = C_PWOK_DEL, // power-good assert delay cycles
  parameter int unsigned P_PWOK_LOW = C_PWOK_LOW, // power-good least low cycles
  parameter int unsigned P_REQ_OFF = C_REQ_OFF, // request-off to disable cycles
  parameter int unsigned P_OFF_HOLD = C_OFF_HOLD, // keep-off cycles
  parameter int unsigned P_BLINK1 = C_BLINK1, // 1 Hz half period cycles
  parameter int unsigned P_BLINK2 = C_BLINK2 // 2 Hz half period cycles
) (
  input wire logic I_CLK, // 200 MHz clock
  input wire logic I_RST_N, // synchronous reset, active low
  input wire logic I_OUTPUT_ON_REQUEST_N, // request, low turns main on
  input wire pssc_stat_t I_STAT, // monitor status bundle
  input wire logic I_LATCH_FAULT, // pulse: a protection has latched off
  input wire logic I_LOW_LOAD, // load current below standby threshold
  input wire logic I_STANDBY_GRANT, // controller permission, cleared by default
  input wire logic I_STANDBY_PERMIT_LINE_IN, // sensed level of permit line
  output logic O_STANDBY_PERMIT_LINE_OUT, // permit line drive value (always 0)
  output logic O_STANDBY_PERMIT_LINE_OE_N, // low while pulling line low
  output logic O_MAIN_EN, // enables main output conversion stage
  output logic O_SHARE_BUS_PIN_CONNECT, // connects share pin to bus
  output logic O_PWOK_OUT, // power-good drive value (always 0)
  output logic O_PWOK_OE_N, // low while pulling power-good low
  output logic O_HOT_STANDBY, // hot-standby mode active
  output logic O_FAULT_LATCHED, // latched fault held
  output pssc_led_t O_LED, // led colour
  output logic O_LED_ON // led lit this cycle
);
  // ---------------------------------------------------------------
  // fault latch and request edge
  // ---------------------------------------------------------------
  logic req_q, fault, next_fault;
  logic req_on;
  assign req_on = !I_OUTPUT_ON_REQUEST_N;
  // a new fault in the toggle cycle wins so it is never lost
  always_comb begin
    next_fault = fault;
    if (req_q != I_OUTPUT_ON_REQUEST_N) next_fault = 1'b0;
    if (I_LATCH_FAULT) next_fault = 1'b1;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      fault <= 1'b0;
      req_q <= 1'b1;
    end else begin
      fault <= next_fault;
      req_q <= I_OUTPUT_ON_REQUEST_N;
    end
  end
  logic any_fault;
  assign any_fault = fault | I_STAT.ot_shut | I_STAT.ov_shut | I_STAT.oc_shut;

  // ---------------------------------------------------------------
  // main output sequencer
  // ---------------------------------------------------------------
  pssc_state_t st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic stby_ok;
  // permit line must be high, load low and grant given
  assign stby_ok = I_STANDBY_PERMIT_LINE_IN & I_LOW_LOAD & I_STANDBY_GRANT;
  always_comb begin
    next_st = st;
    next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
    case (st)
      PSSC_ST_WAIT_SB: begin
        if (I_STAT.sb_ok && req_on && !any_fault) begin
          next_st = PSSC_ST_DELAY;
          next_cnt = CNT_W'(P_SB_MAIN_DEL);
        end
      end
      PSSC_ST_DELAY: begin
        if (!req_on || any_fault || !I_STAT.sb_ok) next_st = PSSC_ST_WAIT_SB;
        else if (cnt == '0) next_st = PSSC_ST_ON;
      end
      PSSC_ST_ON: begin
        if (!req_on) begin
          next_st = PSSC_ST_TURN_OFF;
          next_cnt = CNT_W'(P_REQ_OFF);
        end else if (any_fault || !I_STAT.main_ok || !I_STAT.sb_ok) begin
          next_st = PSSC_ST_HOLD_OFF;
          next_cnt = CNT_W'(P_OFF_HOLD);
        end else if (stby_ok) begin
          next_st = PSSC_ST_STANDBY;
        end
      end
      PSSC_ST_STANDBY: begin
        // conversion is already off: a dropped request or a fault skips the on state
        if (!req_on || any_fault) next_st = PSSC_ST_WAIT_SB;
        // a lowered permit line sends us back to normal running
        else if (!stby_ok) next_st = PSSC_ST_ON;
      end
      PSSC_ST_TURN_OFF: begin
        if (cnt == '0) next_st = PSSC_ST_WAIT_SB;
      end
      PSSC_ST_HOLD_OFF: begin
        if (cnt == '0) next_st = PSSC_ST_WAIT_SB;
      end
      default: next_st = PSSC_ST_WAIT_SB;
    endcase
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= PSSC_ST_WAIT_SB;
      cnt <= '0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
    end
  end
  logic main_on;
  // main stays on through the off delay; conversion stops in hot-standby
  assign main_on = (st == PSSC_ST_ON) || (st == PSSC_ST_TURN_OFF);
  assign O_MAIN_EN = main_on;
  assign O_HOT_STANDBY = (st == PSSC_ST_STANDBY);
  assign O_FAULT_LATCHED = fault;
  assign O_SHARE_BUS_PIN_CONNECT = main_on && !any_fault;
  assign O_STANDBY_PERMIT_LINE_OUT = 1'b0;
  assign O_STANDBY_PERMIT_LINE_OE_N = !any_fault;

  // ---------------------------------------------------------------
  // power-good timing
  // ---------------------------------------------------------------
  logic pwok, next_pwok;
  logic [CNT_W-1:0] pg_cnt, next_pg_cnt;
  logic both_ok;
  logic prev_ok;
  // standby counts as regulating: the other supply carries the load
  assign both_ok = I_STAT.sb_ok && I_STAT.main_ok && req_on && !any_fault
    && (st == PSSC_ST_ON || st == PSSC_ST_STANDBY);
  // dropping the instant the request leaves gives warning ahead of main going off
  always_comb begin
    next_pwok = pwok;
    next_pg_cnt = (pg_cnt == '0) ? pg_cnt : pg_cnt - 1'b1;
    if (pwok) begin
      if (!both_ok) begin
        next_pwok = 1'b0;
        next_pg_cnt = CNT_W'(P_PWOK_LOW);
      end
    end else if (!both_ok) begin
      if (pg_cnt < CNT_W'(P_PWOK_LOW) && pg_cnt < CNT_W'(P_PWOK_DEL)) begin
        next_pg_cnt = pg_cnt;
        if (pg_cnt != '0) next_pg_cnt = pg_cnt - 1'b1;
      end
    end else begin
      // first good cycle only loads the delay, so a spent count cannot rise at once
      if (pg_cnt == '0 && prev_ok) next_pwok = 1'b1;
    end
    if (!pwok && both_ok && !prev_ok) next_pg_cnt = (pg_cnt > CNT_W'(P_PWOK_DEL))
      ? pg_cnt - 1'b1 : CNT_W'(P_PWOK_DEL);
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pwok <= 1'b0;
      pg_cnt <= '0;
      prev_ok <= 1'b0;
    end else begin
      pwok <= next_pwok;
      pg_cnt <= next_pg_cnt;
      prev_ok <= both_ok;
    end
  end
  assign O_PWOK_OUT = 1'b0;
  assign O_PWOK_OE_N = pwok; // open drain: released means high

  // ---------------------------------------------------------------
  // led blink dividers and precedence
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] b1_cnt, next_b1_cnt, b2_cnt, next_b2_cnt;
  logic b1, next_b1, b2, next_b2;
  always_comb begin
    next_b1_cnt = b1_cnt - 1'b1;
    next_b1 = b1;
    next_b2_cnt = b2_cnt - 1'b1;
    next_b2 = b2;
    if (b1_cnt == '0) begin
      next_b1_cnt = CNT_W'(P_BLINK1 - 1);
      next_b1 = !b1;
    end
    if (b2_cnt == '0) begin
      next_b2_cnt = CNT_W'(P_BLINK2 - 1);
      next_b2 = !b2;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      b1_cnt <= '0;
      b2_cnt <= '0;
      b1 <= 1'b0;
      b2 <= 1'b0;
    end else begin
      b1_cnt <= next_b1_cnt;
      b2_cnt <= next_b2_cnt;
      b1 <= next_b1;
      b2 <= next_b2;
    end
  end
  pssc_led_t led, next_led;
  logic led_on, next_led_on;
  // first matching condition wins, in the listed order
  always_comb begin
    next_led = PSSC_LED_OFF;
    next_led_on = 1'b0;
    if (!I_STAT.ac_ok && !I_STAT.sb_ext) begin
      next_led = PSSC_LED_OFF;
    end else if (!req_on || O_HOT_STANDBY) begin
      next_led = PSSC_LED_GREEN;
      next_led_on = b1;
    end else if (!I_STAT.ac_ok || !I_STAT.main_ok || !I_STAT.sb_ok || I_STAT.ot_shut
        || I_STAT.ov_shut || I_STAT.oc_shut || I_STAT.fan_major) begin
      next_led = PSSC_LED_AMBER;
      next_led_on = 1'b1;
    end else if (I_STAT.ot_warn || I_STAT.fan_minor) begin
      next_led = PSSC_LED_AMBER;
      next_led_on = b1;
    end else if (I_STAT.boot_load) begin
      next_led = PSSC_LED_GREEN;
      next_led_on = b2;
    end else begin
      next_led = PSSC_LED_GREEN;
      next_led_on = 1'b1;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      led <= PSSC_LED_OFF;
      led_on <= 1'b0;
    end else begin
      led <= next_led;
      led_on <= next_led_on;
    end
  end
  assign O_LED = led;
  assign O_LED_ON = led_on;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  a_share_off_fault: assert property (any_fault |-> !O_SHARE_BUS_PIN_CONNECT)
    else $error("share pin connected during fault");
  a_main_needs_req: assert property ($rose(O_MAIN_EN) |-> req_on)
    else $error("main enabled without request");
  a_fault_clear: assert property (fault && $changed(I_OUTPUT_ON_REQUEST_N) && !I_LATCH_FAULT
    |=> !fault)
    else $error("fault not cleared on toggle");
  a_pwok_reg: assert property (pwok |-> $past(I_STAT.main_ok && I_STAT.sb_ok))
    else $error("power good without regulation");
  a_pwok_settle: assert property ($rose(pwok) |-> $past(both_ok, 2))
    else $error("power good rose without settle delay");
  a_stby_entry: assert property ($rose(O_HOT_STANDBY) |-> $past(stby_ok))
    else $error("hot standby entered without permission");
  a_stby_conv_off: assert property (O_HOT_STANDBY |-> !O_MAIN_EN)
    else $error("conversion running in hot standby");
  a_permit_pull: assert property (any_fault |-> !O_STANDBY_PERMIT_LINE_OE_N)
    else $error("permit line not pulled on fault");
  a_stby_exit: assert property (O_HOT_STANDBY && !I_STANDBY_PERMIT_LINE_IN
    |=> !O_HOT_STANDBY)
    else $error("hot standby kept with permit low");
  a_pwok_drop_req: assert property (pwok && !req_on |=> !pwok)
    else $error("power good not dropped on request off");
  a_pwok_warn: assert property ($fell(O_MAIN_EN) && st == PSSC_ST_WAIT_SB
    |-> !pwok)
    else $error("no power good warning before main off");
  a_pwok_low_hold: assert property ($fell(pwok) |=> !pwok [*8])
    else $error("power good low time too short");
  a_led_off_first: assert property (!I_STAT.ac_ok && !I_STAT.sb_ext |=> !led_on)
    else $error("led lit without power");
endmodule : pssc_ctrl
`default_nettype wire

// ===== pssc_peer.sv
// partner model: the paralleled supply and the system controller
`timescale 1ns/1ps
`default_nettype none
module pssc_peer (
  input wire logic i_dut_oe_n, // block sinks the permit line when low
  input wire logic i_peer_fault, // the paralleled supply is faulted
  input wire logic i_want_grant, // controller wants the block in standby
  output logic o_permit_line, // wired permit line level
  output logic o_dut_grant, // standby grant to the block
  output logic o_peer_grant // standby grant to the paralleled supply
);
  // pull-up holds the line high unless a faulted supply sinks it
  assign o_permit_line = i_dut_oe_n & ~i_peer_fault;
  // the controller never grants both supplies at once
  assign o_dut_grant = i_want_grant;
  assign o_peer_grant = ~i_want_grant & ~i_peer_fault;
endmodule : pssc_peer
`default_nettype wire

// ===== psu_signaling_status_ctrl_test.sv
// testbench: sequencing, power-good, standby, fault and led checks
`timescale 1ns/1ps
`default_nettype none
module psu_signaling_status_ctrl_test;
  import pssc_pkg::*;
  localparam int SB = 20;
  localparam int PG = 30;
  localparam int OFF = 10;
  localparam int HOLD = 40;
  logic clk, rst_n, req_n, lfault, low_load, want, pfault;
  logic line, grant, permit_o, permit_oe_n, main_en, share, pwok_o, pwok_oe_n, hsb, flt, led_on;
  pssc_stat_t st;
  pssc_led_t led;
  int miscompares = 0;
  int comparisons = 0;
  // stat patterns with the led that must win, blink half period 0 for solid
  logic [10:0] pat [11] = '{11'h280, 11'h380, 11'h6C0, 11'h6A0, 11'h690, 11'h688,
    11'h684, 11'h682, 11'h681, 11'h6C4, 11'h685};
  pssc_led_t col [11] = '{PSSC_LED_OFF, PSSC_LED_AMBER, PSSC_LED_AMBER, PSSC_LED_AMBER,
    PSSC_LED_AMBER, PSSC_LED_AMBER, PSSC_LED_AMBER, PSSC_LED_AMBER, PSSC_LED_GREEN,
    PSSC_LED_AMBER, PSSC_LED_AMBER};
  int hl [11] = '{0, 0, 0, 0, 0, 0, 8, 8, 4, 0, 8};

  pssc_ctrl #(.P_SB_MAIN_DEL(SB), .P_PWOK_DEL(PG), .P_PWOK_LOW(20), .P_REQ_OFF(OFF),
    .P_OFF_HOLD(HOLD), .P_BLINK1(8), .P_BLINK2(4)) uut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_OUTPUT_ON_REQUEST_N(req_n), .I_STAT(st),
    .I_LATCH_FAULT(lfault), .I_LOW_LOAD(low_load), .I_STANDBY_GRANT(grant),
    .I_STANDBY_PERMIT_LINE_IN(line), .O_STANDBY_PERMIT_LINE_OUT(permit_o),
    .O_STANDBY_PERMIT_LINE_OE_N(permit_oe_n), .O_MAIN_EN(main_en),
    .O_SHARE_BUS_PIN_CONNECT(share), .O_PWOK_OUT(pwok_o), .O_PWOK_OE_N(pwok_oe_n),
    .O_HOT_STANDBY(hsb), .O_FAULT_LATCHED(flt), .O_LED(led), .O_LED_ON(led_on));
  pssc_peer peer (.i_dut_oe_n(permit_oe_n), .i_peer_fault(pfault), .i_want_grant(want),
    .o_permit_line(line), .o_dut_grant(grant), .o_peer_grant());

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // inputs always move 1 ns after the edge so no race with the design
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  // colour, then toggles over 32 cycles: a blink of half period h toggles 32/h times
  task automatic led_chk(input pssc_led_t c, input int h);
    logic [7:0] n;
    logic prev;
    n = 8'h00;
    cyc(3);
    chk(8'(led), 8'(c));
    prev = led_on;
    repeat (32) begin
      cyc(1);
      if (led_on !== prev) n++;
      prev = led_on;
    end
    chk(n, (h == 0) ? 8'h00 : 8'(32 / h));
    if (h == 0) chk(8'(led_on), 8'(c != PSSC_LED_OFF));
  endtask : led_chk
  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    cyc(6000);
    miscompares++;
    print_verdict();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; req_n = 1'b1; lfault = 1'b0; low_load = 1'b0; want = 1'b0; pfault = 1'b0;
    st = pssc_stat_t'(11'h680);
    cyc(4);
    rst_n = 1'b1;
    req_n = 1'b0;
    cyc(SB - 2);
    chk(8'(main_en), 8'h00);
    cyc(6);
    chk(8'(main_en), 8'h01);
    chk(8'(share), 8'h01);
    cyc(PG - 10);
    chk(8'(pwok_oe_n), 8'h00);
    cyc(15);
    chk(8'(pwok_oe_n), 8'h01);
    chk(8'(pwok_o), 8'h00);
    led_chk(PSSC_LED_GREEN, 0);
    for (int i = 0; i < 11; i++) begin
      st = pssc_stat_t'(pat[i]);
      led_chk(col[i], hl[i]);
    end
    st = pssc_stat_t'(11'h680);
    cyc(SB + PG + 10);
    // hot-standby needs all three conditions; the grant starts off
    low_load = 1'b1;
    cyc(5);
    chk(8'(hsb), 8'h00);
    want = 1'b1;
    low_load = 1'b0;
    cyc(5);
    chk(8'(hsb), 8'h00);
    low_load = 1'b1;
    cyc(5);
    chk(8'(hsb), 8'h01);
    chk(8'(main_en), 8'h00);
    led_chk(PSSC_LED_GREEN, 8);
    pfault = 1'b1;
    cyc(5);
    chk(8'(hsb), 8'h00);
    pfault = 1'b0; want = 1'b0; low_load = 1'b0;
    cyc(SB + PG + 10);
    // latched fault: sinks the permit line, frees the share bus, clears on toggle
    lfault = 1'b1;
    cyc(1);
    lfault = 1'b0;
    cyc(2);
    chk(8'(flt), 8'h01);
    chk(8'(permit_oe_n), 8'h00);
    chk(8'(line), 8'h00);
    chk(8'(permit_o), 8'h00);
    chk(8'(share), 8'h00);
    cyc(SB + 5);
    chk(8'(main_en), 8'h00);
    req_n = 1'b1;
    cyc(2);
    req_n = 1'b0;
    cyc(2);
    chk(8'(flt), 8'h00);
    chk(8'(permit_oe_n), 8'h01);
    cyc(SB + PG + 30);
    chk(8'(pwok_oe_n), 8'h01);
    // request off: power-good falls first, main follows after the off delay
    req_n = 1'b1;
    cyc(2);
    chk(8'(pwok_oe_n), 8'h00);
    chk(8'(main_en), 8'h01);
    cyc(OFF - 4);
    chk(8'(main_en), 8'h01);
    cyc(8);
    chk(8'(main_en), 8'h00);
    chk(8'(share), 8'h00);
    led_chk(PSSC_LED_GREEN, 8);
    st = pssc_stat_t'(11'h6C0);
    led_chk(PSSC_LED_GREEN, 8);
    st = pssc_stat_t'(11'h280);
    led_chk(PSSC_LED_OFF, 0);
    st = pssc_stat_t'(11'h680);
    req_n = 1'b0;
    cyc(SB + PG + 10);
    // loss of regulation: power-good drops, main kept off for the hold time
    st.main_ok = 1'b0;
    cyc(3);
    chk(8'(pwok_oe_n), 8'h00);
    chk(8'(main_en), 8'h00);
    led_chk(PSSC_LED_AMBER, 0);
    chk(8'(main_en), 8'h00);
    st.main_ok = 1'b1;
    cyc(SB + 25);
    chk(8'(main_en), 8'h01);
    print_verdict();
  end
endmodule : psu_signaling_status_ctrl_test
`default_nettype wire
